/* hdl/adsp_regs.svh */
/*
 constants of the serial data port and frame builder of the eight-channel converter.
 assumes clk_sys is the master clock and that it runs at 100 MHz.
*/
// Functional notes
// - samples are 16-bit two's complement, msb first
// - samples clip at 7FFF and 8000
// - clock select pin picks external or internal clock
// - select high resets port, floats data out
// - ready flag asserts each conversion, ignoring select
// - eighth falling edge executes byte; select resyncs
// - data in sampled on serial clock fall
// - data out changes on rise, floats deselected
// - continuous mode data out mirrors ready
// - continuous read or single read command
// - msb after first rise, ready clears first fall
// - frame is 24 status plus eight samples
// - status is 1100, faults, gpio bits 7:4
// - powered-down channel sends zero, order kept
// - chain select repeats frame past its end
// - per-channel sinc3 decimator at 8 kSPS
// - step settles within three output periods
// - reference buffer off until power bit set
// - modulator runs at master clock over eight
`ifndef ADSP_REGS_SVH
`define ADSP_REGS_SVH

// rates and derived counts
`define ADSP_MCLK_HZ    32'h05F5E100
`define ADSP_MOD_DIV    4'h8
`define ADSP_ODR_HZ     32'h00001F40
`define ADSP_MOD_HZ     (`ADSP_MCLK_HZ / `ADSP_MOD_DIV)
`define ADSP_DEC_N      (`ADSP_MOD_HZ / `ADSP_ODR_HZ)
`define ADSP_SHIFT      5'h10

// frame layout
`define ADSP_FRAME_BITS 8'h98
`define ADSP_STAT_BITS  8'h18
`define ADSP_SMP_BITS   8'h10
`define ADSP_STATUS_HDR 4'hC
`define ADSP_POS_FS     16'h7FFF
`define ADSP_NEG_FS     16'h8000

// serial opcodes
`define ADSP_OP_CONTINUOUS_READ_MODE  8'h10
`define ADSP_OP_SDATAC  8'h11
`define ADSP_OP_RDATA   8'h12

`endif

/* hdl/adsp_pkg.sv */
/*
 types of the serial data port: read mode and the whole state record.
 assumes adsp_regs.svh for the figures.
*/
`default_nettype none
package adsp_pkg;

    // read mode of the port
    typedef enum logic [1:0] {
        ADSP_IDLE   = 2'b00,
        ADSP_SINGLE = 2'b01,
        ADSP_CONT   = 2'b10
    } adsp_mode_t;

    // all registered state of the block
    typedef struct packed {
        logic [5:0]        s1;
        logic [5:0]        s2;
        logic              sclk_p;
        logic [2:0]        modc;
        logic [10:0]       decc;
        logic [7:0][33:0]  i1;
        logic [7:0][33:0]  i2;
        logic [7:0][33:0]  i3;
        logic [7:0][33:0]  c1;
        logic [7:0][33:0]  c2;
        logic [7:0][33:0]  c3;
        logic [151:0]      frame;
        logic [151:0]      snap;
        logic [7:0]        idx;
        logic [2:0]        bits;
        logic [7:0]        rx;
        adsp_mode_t        mode;
        logic              started;
        logic              ready_n;
        logic              dout;
        logic              oe;
        logic              use_int;
        logic              clk_o;
        logic              clk_oe;
        logic              mclk;
        logic              ref_on;
    } adsp_state_t;

endpackage
`default_nettype wire

/* hdl/adsp_port.sv */
/*
 serial data port, frame builder and sinc3 decimators of the converter.
 assumes modulator bits, faults and gpio levels come from clk_sys logic;
 select, serial clock, data in, clock pins and clock select are asynchronous.
*/
`include "adsp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module adsp_port (
    input  wire logic        clk_sys,                          // master clock
    input  wire logic        rst_n,                            // sync reset, low
    input  wire logic        chip_select_n,                    // spi select, low
    input  wire logic        serial_clk,                       // spi clock
    input  wire logic        serial_din,                       // spi data in
    output var  logic        serial_dout,                      // spi data out
    output var  logic        serial_dout_oe,                   // data out drive
    output var  logic        conversion_ready_flag_n,          // ready, low
    output var  logic        continuous_read_mode,             // cont mode on
    input  wire logic [7:0]  mod_bits,                         // modulator bits
    input  wire logic [7:0]  chan_powered_down,                // per channel
    input  wire logic [7:0]  positive_fault_comparator_status, // faults high
    input  wire logic [7:0]  negative_fault_comparator_status, // faults low
    input  wire logic [3:0]  gpio_level_bits,                  // gpio bits 7:4
    input  wire logic        chain_input_select,               // repeat frame
    input  wire logic        clock_source_select_pin,          // 1 internal
    input  wire logic        clock_output_enable,              // drive osc out
    input  wire logic        osc_level,                        // oscillator
    input  wire logic        clk_pin_in,                       // clock pin in
    output var  logic        clk_pin_out,                      // clock pin out
    output var  logic        clk_pin_oe,                       // clock pin drive
    output var  logic        internal_clock_active,            // osc in use
    output var  logic        master_clk_level,                 // chosen clock
    input  wire logic        reference_buffer_power_bit,       // buffer on req
    output var  logic        reference_buffer_on               // buffer powered
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // scale and clip a decimator output to a sample
    function automatic logic [15:0] adsp_sat16(input logic signed [33:0] v);
        logic signed [17:0] s;
        s = 18'(v >>> `ADSP_SHIFT);
        if (s > 18'sh07FFF) begin
            return `ADSP_POS_FS;
        end
        if (s < 18'sh38000) begin
            return `ADSP_NEG_FS;
        end
        return s[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    adsp_pkg::adsp_state_t q;
    adsp_pkg::adsp_state_t d;
    logic [7:0][33:0]      dec_y;
    logic                  mod_en;
    logic                  conv;
    logic                  cs_hi;
    logic                  sclk;
    logic                  din;
    logic                  rise;
    logic                  fall;
    logic                  reading;
    logic [7:0]            byte_in;
    logic [7:0]            bit_sel;

    // modulator rate enable and conversion pulse
    assign mod_en  = (q.modc == 3'(`ADSP_MOD_DIV - 1));
    assign conv    = mod_en && (q.decc == 11'(`ADSP_DEC_N - 1));

    // synchronised pins and serial clock edges
    assign cs_hi   = q.s2[0];
    assign sclk    = q.s2[1];
    assign din     = q.s2[2];
    assign rise    = sclk && !q.sclk_p;
    assign fall    = !sclk && q.sclk_p;
    assign reading = (q.mode != adsp_pkg::ADSP_IDLE);
    assign byte_in = {q.rx[6:0], din};
    assign bit_sel = 8'(`ADSP_FRAME_BITS - 8'h01) - q.idx;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;

        // two flops on every asynchronous input
        d.s1 = {clk_pin_in, osc_level, clock_source_select_pin,
                serial_din, serial_clk, chip_select_n};
        d.s2 = q.s1;
        d.sclk_p = sclk;

        // modulator rate divider and decimation counter
        d.modc = q.modc + 3'h1;
        if (mod_en) begin
            d.decc = conv ? 11'h000 : q.decc + 11'h001;
        end

        // sinc3 per channel: integrators at modulator rate
        for (int k = 0; k < 8; k++) begin
            if (mod_en) begin
                d.i1[k] = q.i1[k] + (mod_bits[k] ? 34'h000000001
                                                 : 34'h3FFFFFFFF);
                d.i2[k] = q.i2[k] + q.i1[k];
                d.i3[k] = q.i3[k] + q.i2[k];
            end
            // three comb stages at output rate; settles in three periods
            dec_y[k] = q.i3[k] - q.c1[k] - q.c2[k] - q.c3[k];
            if (conv) begin
                d.c1[k] = q.i3[k];
                d.c2[k] = q.i3[k] - q.c1[k];
                d.c3[k] = q.i3[k] - q.c1[k] - q.c2[k];
            end
        end

        // frame capture: status word then channels one to eight
        if (conv) begin
            d.frame[151:128] = {`ADSP_STATUS_HDR,
                                positive_fault_comparator_status,
                                negative_fault_comparator_status,
                                gpio_level_bits};
            for (int k = 0; k < 8; k++) begin
                d.frame[127 - 16 * k -: 16] = chan_powered_down[k]
                    ? 16'h0000
                    : adsp_sat16(dec_y[k]);
            end
        end

        // clock source and pin direction
        d.use_int = q.s2[3];
        d.clk_oe  = q.s2[3] && clock_output_enable;
        d.clk_o   = q.s2[4];
        d.mclk    = q.s2[3] ? q.s2[4] : q.s2[5];

        // reference buffer follows its power bit, off after reset
        d.ref_on  = reference_buffer_power_bit;

        // serial port
        if (cs_hi) begin
            // deselected: clear counters, float data out
            d.bits    = 3'h0;
            d.idx     = 8'h00;
            d.started = 1'b0;
            d.oe      = 1'b0;
            d.dout    = 1'b0;
            if (q.mode == adsp_pkg::ADSP_SINGLE) begin
                d.mode = adsp_pkg::ADSP_IDLE;
            end
        end else begin
            d.oe = 1'b1;
            // command bytes shift in on falling edges
            if (fall) begin
                d.rx   = byte_in;
                d.bits = q.bits + 3'h1;
                d.ready_n = 1'b1;
                if (q.bits == 3'h7) begin
                    case (byte_in)
                        `ADSP_OP_CONTINUOUS_READ_MODE: d.mode = adsp_pkg::ADSP_CONT;
                        `ADSP_OP_SDATAC: d.mode = adsp_pkg::ADSP_IDLE;
                        `ADSP_OP_RDATA: begin
                            if (q.mode != adsp_pkg::ADSP_CONT) begin
                                d.mode    = adsp_pkg::ADSP_SINGLE;
                                d.idx     = 8'h00;
                                d.started = 1'b0;
                            end
                        end
                        default: d.mode = q.mode;
                    endcase
                end
            end
            // frame bits shift out on rising edges
            if (rise && reading) begin
                case (q.mode)
                    adsp_pkg::ADSP_SINGLE, adsp_pkg::ADSP_CONT: begin
                        if (!q.started) begin
                            d.snap    = q.frame;
                            d.dout    = q.frame[151];
                            d.idx     = 8'h01;
                            d.started = 1'b1;
                        end else if (q.idx != `ADSP_FRAME_BITS) begin
                            d.dout = q.snap[bit_sel];
                            d.idx  = q.idx + 8'h01;
                        end else if (chain_input_select) begin
                            d.dout = q.snap[151];
                            d.idx  = 8'h01;
                        end else begin
                            d.dout = 1'b0;
                            if (q.mode == adsp_pkg::ADSP_SINGLE) begin
                                d.mode = adsp_pkg::ADSP_IDLE;
                            end
                        end
                    end
                    default: d.dout = 1'b0;
                endcase
            end else if (q.mode == adsp_pkg::ADSP_CONT && !q.started) begin
                d.dout = q.ready_n;
            end
        end

        // conversion ready wins over a same-cycle clear
        if (conv) begin
            d.ready_n = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // synchronous reset, ready idles high
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q         <= '0;
            q.ready_n <= 1'b1;
            q.s1      <= 6'h01;
            q.s2      <= 6'h01;
        end else begin
            q <= d;
        end
    end

    // outputs straight from state
    assign serial_dout             = q.dout;
    assign serial_dout_oe          = q.oe;
    assign conversion_ready_flag_n = q.ready_n;
    assign continuous_read_mode    = (q.mode == adsp_pkg::ADSP_CONT);
    assign clk_pin_out             = q.clk_o;
    assign clk_pin_oe              = q.clk_oe;
    assign internal_clock_active   = q.use_int;
    assign master_clk_level        = q.mclk;
    assign reference_buffer_on     = q.ref_on;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking adsp_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // deselect floats data out next cycle and clears the index
    hiz_on_deselect_a: assert property (cs_hi |=> !serial_dout_oe && q.idx == 8'h00)
        else $error("data out driven while deselected");

    // ready goes low the cycle after every conversion
    ready_on_conv_a: assert property (conv |=> !conversion_ready_flag_n)
        else $error("ready missed a conversion");

    // first falling edge while selected clears ready
    ready_clear_a: assert property (fall && !cs_hi && !conv |=> conversion_ready_flag_n)
        else $error("ready not cleared by falling edge");

    // eighth falling edge wraps the bit counter
    byte_wrap_a: assert property (fall && !cs_hi && q.bits == 3'h7 |=> q.bits == 3'h0)
        else $error("byte counter did not wrap");

    // status header leads every captured frame
    status_head_a: assert property (conv |=> q.frame[151:148] == `ADSP_STATUS_HDR)
        else $error("status header missing");

    // powered-down channel three carries zero
    pd_zero_a: assert property (conv && chan_powered_down[2] |=> q.frame[95:80] == 16'h0000)
        else $error("powered-down slot not zero");

    // overrange clips at positive full scale
    clip_pos_a: assert property (conv && !chan_powered_down[0]
        && $signed(dec_y[0]) >= 34'sh080000000 |=> q.frame[127:112] == `ADSP_POS_FS)
        else $error("positive overrange not clipped");

    // underrange on channel two clips at negative full scale
    clip_neg_a: assert property (conv && !chan_powered_down[1]
        && $signed(dec_y[1]) < 34'sh37FFF0000 |=> q.frame[111:96] == `ADSP_NEG_FS)
        else $error("negative overrange not clipped");

    // modulator enable every eighth cycle
    mod_rate_a: assert property (mod_en |=> !mod_en [*7] ##1 mod_en)
        else $error("modulator rate wrong");

    // clock pin floats on internal clock without output enable
    clk_pin_float_a: assert property (q.s2[3] && !clock_output_enable |=> !clk_pin_oe)
        else $error("clock pin driven when it should float");

    // reference buffer stays off without its power bit
    ref_off_a: assert property (!reference_buffer_power_bit |=> !reference_buffer_on)
        else $error("reference buffer on without request");

    // first rising edge of a read puts the frame msb out
    msb_first_a: assert property (rise && !cs_hi && reading && !q.started
        |=> serial_dout == $past(q.frame[151]))
        else $error("frame msb not first");

endmodule

`default_nettype wire

/* verification/adsp_host.sv */
/*
 host-side spi master model driving the converter's serial port.
 assumes an idle-low serial clock of 125 ns period; the bench calls its tasks.
*/
`timescale 1ns/1ps
`default_nettype none

module adsp_host (
    output var  logic chip_select_n,  // select, low
    output var  logic serial_clk,     // link clock
    output var  logic serial_din,     // host to device
    input  wire logic serial_dout,    // device to host
    input  wire logic serial_dout_oe  // device drives line
);
    localparam realtime HALF = 62.5;

    // idle: deselected, clock parked low between frames
    initial begin
        chip_select_n = 1'b1;
        serial_clk    = 1'b0;
        serial_din    = 1'b0;
    end

    // select and give setup before the first edge
    task automatic selectdev();
        chip_select_n = 1'b0;
        #(HALF);
    endtask

    // wait over four master clocks before raising select
    task automatic deselect();
        #100;
        chip_select_n = 1'b1;
        serial_din    = 1'b0;
        #(HALF);
    endtask

    // n bits msb first; a floating data out reads as z
    task automatic shift(input int n, input logic [175:0] tx, output logic [175:0] rx);
        rx = '0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_din = tx[i];
            serial_clk = 1'b1;
            #(HALF);
            rx = {rx[174:0], serial_dout_oe ? serial_dout : 1'bz};
            serial_clk = 1'b0;
            #(HALF);
        end
    endtask
endmodule
`default_nettype wire

/* verification/tb_adsp_port.sv */
/*
 self-checking bench of the serial data port: clock pin table, reads, modes.
 assumes adsp_port and the host model; conversion period 12496 clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_adsp_port;
    // rows: sel en osc pin refbit | clk_oe int_active mclk ref_on
    localparam logic [8:0] ROWS [5] = '{9'h040, 9'h0B3, 9'h146, 9'h1BD, 9'h1CE};
    // expected frame: header, faults, gpio, ch1 full+, ch2 full-, ch3 off, rest full-
    localparam logic [151:0] FRAME = {4'hC, 8'hA5, 8'h3C, 4'h9, 16'h7FFF, 16'h8000,
                                      16'h0000, {5{16'h8000}}};

    logic         clk_sys = 1'b0;
    logic         rst_n, cs_n, sclk, din, dout, dout_oe, ready_n, cont;
    logic         chain, clk_sel, clk_en, osc, pin_in, ref_bit;
    logic         pin_out, pin_oe, int_act, mclk_lvl, ref_on;
    logic [175:0] rx;
    int           n_mismatch = 0;
    int           checks = 0;
    int           n;

    always #5 clk_sys = ~clk_sys;

    adsp_host host (.chip_select_n(cs_n), .serial_clk(sclk), .serial_din(din),
                    .serial_dout(dout), .serial_dout_oe(dout_oe));

    adsp_port dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .chip_select_n(cs_n), .serial_clk(sclk),
        .serial_din(din), .serial_dout(dout), .serial_dout_oe(dout_oe),
        .conversion_ready_flag_n(ready_n), .continuous_read_mode(cont),
        .mod_bits(8'h01), .chan_powered_down(8'h04),
        .positive_fault_comparator_status(8'hA5), .negative_fault_comparator_status(8'h3C),
        .gpio_level_bits(4'h9), .chain_input_select(chain),
        .clock_source_select_pin(clk_sel), .clock_output_enable(clk_en), .osc_level(osc),
        .clk_pin_in(pin_in), .clk_pin_out(pin_out), .clk_pin_oe(pin_oe),
        .internal_clock_active(int_act), .master_clk_level(mclk_lvl),
        .reference_buffer_power_bit(ref_bit), .reference_buffer_on(ref_on));

    // compare and count
    task automatic check(input logic [175:0] seen, input logic [175:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    // counts, verdict, end of run
    task automatic finish_test();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // let synchronisers settle
    task automatic settle();
        repeat (6) @(negedge clk_sys);
    endtask

    // cut a hang short
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_mismatch++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst_n, chain, clk_sel, clk_en, osc, pin_in, ref_bit} = 7'h00;
        repeat (16) @(negedge clk_sys);
        check({dout_oe, ready_n, cont, pin_oe, ref_on}, 5'h08);
        rst_n = 1'b1;
        settle();
        check(ref_on, 1'b0);
        // clock pin and reference buffer table
        foreach (ROWS[k]) begin
            {clk_sel, clk_en, osc, pin_in, ref_bit} = ROWS[k][8:4];
            settle();
            check({pin_oe, int_act, mclk_lvl, ref_on}, ROWS[k][3:0]);
            check(pin_out, osc);
        end
        // four conversions so every decimator has settled
        chain = 1'b1;
        repeat (4 * 12496) @(negedge clk_sys);
        check({ready_n, dout_oe}, 2'b00);
        // single read with frame repeat past its end
        host.selectdev();
        host.shift(176, {8'h12, 168'h0}, rx);
        check(ready_n, 1'b1);
        check(rx[167:0], {FRAME, FRAME[151:136]});
        host.deselect();
        settle();
        check(dout_oe, 1'b0);
        // broken partial byte, then resync by select
        host.selectdev();
        host.shift(3, 176'h7, rx);
        host.deselect();
        host.selectdev();
        host.shift(8, 176'h10, rx);
        host.deselect();
        settle();
        check(cont, 1'b1);
        // continuous read of the next conversion, no repeat
        chain = 1'b0;
        n = 0;
        while (ready_n !== 1'b0 && n < 13000) begin
            @(negedge clk_sys);
            n++;
        end
        check(ready_n, 1'b0);
        host.selectdev();
        settle();
        check({dout_oe, dout}, 2'b10);
        host.shift(160, 176'h0, rx);
        check(rx[159:0], {FRAME, 8'h00});
        host.deselect();
        // leave continuous mode
        host.selectdev();
        host.shift(8, 176'h11, rx);
        host.deselect();
        settle();
        check(cont, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
